/* design/asa_pkg.sv */
// Shared constants and types for the alarm status aggregator
package asa_pkg;

  // Bus and vector widths
  localparam int ASA_ADDR_W = 12;
  localparam int ASA_DATA_W = 8;
  localparam int ASA_LANES  = 16;
  localparam int ASA_FLAGS  = 6;

  // Register offsets, byte addresses on the plain register port
  localparam logic [11:0] ASA_OFS_SUMMARY  = 12'h2C0;
  localparam logic [11:0] ASA_OFS_STATUS   = 12'h2C1;
  localparam logic [11:0] ASA_OFS_MASK     = 12'h2C2;
  localparam logic [11:0] ASA_OFS_LANE_LO  = 12'h2C4;
  localparam logic [11:0] ASA_OFS_LANE_HI  = 12'h2C5;
  localparam logic [11:0] ASA_OFS_CTRL     = 12'h2C8;
  localparam logic [11:0] ASA_OFS_IRQ_ST   = 12'h2C9;
  localparam logic [11:0] ASA_OFS_IRQ_MASK = 12'h2CA;

  // Values after reset
  localparam logic [5:0]  ASA_FLAG_RST     = 6'h3F;
  localparam logic [5:0]  ASA_MASK_RST     = 6'h3F;
  localparam logic [5:0]  ASA_IRQ_MASK_RST = 6'h00;
  localparam logic [15:0] ASA_LANE_RST     = 16'hFFFF;

  // Field positions in status and mask registers
  localparam int ASA_B_DIVIDER = 0;
  localparam int ASA_B_UNUSED  = 1;
  localparam int ASA_B_REALIGN = 2;
  localparam int ASA_B_LINK    = 3;
  localparam int ASA_B_SYNTH   = 4;
  localparam int ASA_B_LANE    = 5;

  // Field positions in the control register
  localparam int ASA_C_LINK_EN  = 0;
  localparam int ASA_C_MODE     = 1;
  localparam int ASA_C_PIN_SEL  = 2;
  localparam int ASA_C_SOFT_RST = 3;

  // Positions in the synchronised raw event vector
  localparam int ASA_E_DIVIDER = 0;
  localparam int ASA_E_SYSREF  = 1;
  localparam int ASA_E_RELINK  = 2;
  localparam int ASA_E_NOTDATA = 3;
  localparam int ASA_E_LOCKED  = 4;
  localparam int ASA_E_LANE0   = 5;

  // Link line coding
  typedef enum logic [0:0] {
    ASA_MODE_8B10B  = 1'b0,
    ASA_MODE_64B66B = 1'b1
  } asa_mode_e;

endpackage

/* design/asa_evt_if.sv */
// Synchronised alarm sources passed from the event front end to the core
`timescale 1ns/1ps
interface asa_evt_if #(
  parameter int LANES = 16
);
  logic [LANES-1:0] laneFault;
  logic             pllUnlock;
  logic             notDataState;
  logic             linkRealign;
  logic             sysrefRealign;
  logic             divMismatch;

  modport src (
    output laneFault, pllUnlock, notDataState, linkRealign, sysrefRealign, divMismatch
  );
  modport dst (
    input  laneFault, pllUnlock, notDataState, linkRealign, sysrefRealign, divMismatch
  );
endinterface

/* design/asa_event_sync.sv */
// Two-flop synchronisers and edge detectors for the raw alarm sources
`timescale 1ns/1ps
module asa_event_sync #(
  parameter int LANES = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [LANES-1:0] laneFaultRaw,
  input  wire logic             pllLockedRaw,
  input  wire logic             notDataStateRaw,
  input  wire logic             linkRealignRaw,
  input  wire logic             sysrefRealignRaw,
  input  wire logic             divMismatchRaw,
  asa_evt_if.src                evt
);
  import asa_pkg::*;

  localparam int W = LANES + 5;

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
  } asa_sync_s;

  asa_sync_s st;
  asa_sync_s next_st;

  // Lock starts low so an unlock is seen until the synchroniser fills
  always_comb begin
    next_st        = st;
    next_st.stage1 = {laneFaultRaw, pllLockedRaw, notDataStateRaw, linkRealignRaw,
                      sysrefRealignRaw, divMismatchRaw};
    next_st.stage2 = st.stage1;
    next_st.stage3 = st.stage2;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Levels come from stage2; realign events are rising edges only
  assign evt.laneFault     = st.stage2[W-1:ASA_E_LANE0];
  assign evt.pllUnlock     = ~st.stage2[ASA_E_LOCKED];
  assign evt.notDataState  = st.stage2[ASA_E_NOTDATA];
  assign evt.linkRealign   = st.stage2[ASA_E_RELINK] & ~st.stage3[ASA_E_RELINK];
  assign evt.sysrefRealign = st.stage2[ASA_E_SYSREF] & ~st.stage3[ASA_E_SYSREF];
  assign evt.divMismatch   = st.stage2[ASA_E_DIVIDER];

endmodule

/* design/alarm_status_aggregator.sv */
// Alarm flag collection, masking, summary and interrupt for the serial link
//
// Overview of operation
// - Summary is 1 when any status flag is set with its mask bit clear.
// - A set mask bit hides its flag from summary; the flag still records.
// - Pin selection set to alarm drives summary onto the calibration status pin.
// - Any active lane buffer over/underflow sets flag bit 5.
// - Sixteen per-lane alarm bits, write-1 clears; clearing bit 5 clears all.
// - Synthesizer not locked sets flag bit 4.
// - 8b/10b mode: link enabled but not in data state sets flag bit 3.
// - 64b/66b mode: link start-up or any realignment sets flag bit 3.
// - SYSREF realignment of internal clocks sets flag bit 2.
// - Channel A and B divider mismatch sets flag bit 0.
// - Flags clear only on write of 1; writing 0 leaves them.
// - Power-on or soft reset sets all six flags, status reads 0x3F.
// - With link disabled only the divider flag is meaningful; clear after enable.
// - Mask register resets to 0x3F, all alarms masked.
// - Summary register is read-only, bits 7:1 read zero.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module alarm_status_aggregator (
  input  wire logic                            core_clk,
  input  wire logic                            rst,
  input  wire logic [asa_pkg::ASA_ADDR_W-1:0]  address,
  input  wire logic [asa_pkg::ASA_DATA_W-1:0]  writeData,
  input  wire logic                            writeStrobe,
  input  wire logic                            readStrobe,
  output logic      [asa_pkg::ASA_DATA_W-1:0]  readData,
  input  wire logic [asa_pkg::ASA_LANES-1:0]   laneFaultRaw,
  input  wire logic [asa_pkg::ASA_LANES-1:0]   laneActive,
  input  wire logic                            pllLockedRaw,
  input  wire logic                            notDataStateRaw,
  input  wire logic                            linkRealignRaw,
  input  wire logic                            sysrefRealignRaw,
  input  wire logic                            divMismatchRaw,
  input  wire logic                            calStatus,
  output logic                                 cal_status_output_pin,
  output logic                                 serial_link_enable,
  output logic                                 linkMode64,
  output logic                                 irq
);
  import asa_pkg::*;

  typedef struct packed {
    logic [5:0]  flag_status_bank;
    logic [5:0]  flag_mask_bank;
    logic [15:0] per_lane_buffer_flags;
    logic [5:0]  irqStatus;
    logic [5:0]  irqMask;
    logic        linkEnable;
    asa_mode_e   mode;
    logic        pinSelAlarm;
    logic        prevLinkEnable;
    logic [7:0]  rdata;
    logic        irqOut;
    logic        pinOut;
  } asa_core_s;

  localparam asa_core_s ST_RST = '{
    flag_status_bank:      ASA_FLAG_RST,
    flag_mask_bank:        ASA_MASK_RST,
    per_lane_buffer_flags: ASA_LANE_RST,
    irqStatus:             6'h00,
    irqMask:               ASA_IRQ_MASK_RST,
    linkEnable:            1'b0,
    mode:                  ASA_MODE_8B10B,
    pinSelAlarm:           1'b0,
    prevLinkEnable:        1'b0,
    rdata:                 8'h00,
    irqOut:                1'b0,
    pinOut:                1'b0
  };

  asa_core_s st;
  asa_core_s next_st;

  asa_evt_if #(.LANES(ASA_LANES)) evt ();

  // Pin sources cross into core_clk through two flops each
  asa_event_sync #(
    .LANES            (ASA_LANES)
  ) u_sync (
    .core_clk         (core_clk),
    .rst              (rst),
    .laneFaultRaw     (laneFaultRaw),
    .pllLockedRaw     (pllLockedRaw),
    .notDataStateRaw  (notDataStateRaw),
    .linkRealignRaw   (linkRealignRaw),
    .sysrefRealignRaw (sysrefRealignRaw),
    .divMismatchRaw   (divMismatchRaw),
    .evt              (evt)
  );

  logic        wrStatus;
  logic        wrMask;
  logic        wrLaneLo;
  logic        wrLaneHi;
  logic        wrCtrl;
  logic        wrIrqMask;
  logic        rdIrqStatus;
  logic        softReset;
  logic [15:0] laneHits;
  logic [15:0] laneClear;
  logic [5:0]  flagClear;
  logic [5:0]  setVec;
  logic        summary;
  logic [7:0]  readMux;

  // Address decode; summary has no write decode at all
  // summary ignores writes
  assign wrStatus    = writeStrobe && (address == ASA_OFS_STATUS);
  assign wrMask      = writeStrobe && (address == ASA_OFS_MASK);
  assign wrLaneLo    = writeStrobe && (address == ASA_OFS_LANE_LO);
  assign wrLaneHi    = writeStrobe && (address == ASA_OFS_LANE_HI);
  assign wrCtrl      = writeStrobe && (address == ASA_OFS_CTRL);
  assign wrIrqMask   = writeStrobe && (address == ASA_OFS_IRQ_MASK);
  assign rdIrqStatus = readStrobe && (address == ASA_OFS_IRQ_ST);
  assign softReset   = wrCtrl && writeData[ASA_C_SOFT_RST];

  // Only lanes that are in use may raise the lane buffer alarm
  // active lanes only
  assign laneHits = evt.laneFault & laneActive;

  // per-lane write-1 clear, bit 5 clears all
  assign laneClear = (wrStatus && writeData[ASA_B_LANE]) ? 16'hFFFF :
                     {(wrLaneHi ? writeData : 8'h00), (wrLaneLo ? writeData : 8'h00)};

  assign flagClear = wrStatus ? writeData[5:0] : 6'h00;

  // Set conditions, evaluated every cycle as levels
  always_comb begin
    setVec = 6'h00;
    setVec[ASA_B_LANE] = |laneHits;
    setVec[ASA_B_SYNTH] = evt.pllUnlock;
    if (st.mode == ASA_MODE_8B10B) begin
      setVec[ASA_B_LINK] = st.linkEnable && evt.notDataState;
    end else begin
      setVec[ASA_B_LINK] = st.linkEnable &&
                           ((!st.prevLinkEnable) || evt.linkRealign);
    end
    setVec[ASA_B_REALIGN] = evt.sysrefRealign;
    setVec[ASA_B_UNUSED] = 1'b0;
    // divider mismatch, valid even while link disabled
    setVec[ASA_B_DIVIDER] = evt.divMismatch;
  end

  assign summary = |(st.flag_status_bank & ~st.flag_mask_bank);

  // Read mux; reserved bits and unmapped addresses read zero
  always_comb begin
    case (address)
      ASA_OFS_SUMMARY: begin
        readMux = {7'h00, summary};
      end
      ASA_OFS_STATUS: begin
        readMux = {2'b00, st.flag_status_bank};
      end
      ASA_OFS_MASK: begin
        readMux = {2'b00, st.flag_mask_bank};
      end
      ASA_OFS_LANE_LO: begin
        readMux = st.per_lane_buffer_flags[7:0];
      end
      ASA_OFS_LANE_HI: begin
        readMux = st.per_lane_buffer_flags[15:8];
      end
      ASA_OFS_CTRL: begin
        readMux = {5'h00, st.pinSelAlarm, st.mode, st.linkEnable};
      end
      ASA_OFS_IRQ_ST: begin
        readMux = {2'b00, st.irqStatus};
      end
      ASA_OFS_IRQ_MASK: begin
        readMux = {2'b00, st.irqMask};
      end
      default: begin
        readMux = 8'h00;
      end
    endcase
  end

  // Next state of the whole block
  always_comb begin
    next_st = st;
    next_st.prevLinkEnable = st.linkEnable;
    next_st.flag_status_bank = (st.flag_status_bank & ~flagClear) | setVec;
    next_st.per_lane_buffer_flags = (st.per_lane_buffer_flags & ~laneClear) | laneHits;
    if (wrMask) begin
      next_st.flag_mask_bank = writeData[5:0];
    end
    if (wrCtrl) begin
      next_st.linkEnable  = writeData[ASA_C_LINK_EN];
      next_st.mode        = asa_mode_e'(writeData[ASA_C_MODE]);
      next_st.pinSelAlarm = writeData[ASA_C_PIN_SEL];
    end
    if (wrIrqMask) begin
      next_st.irqMask = writeData[5:0];
    end
    // Read clears the interrupt status, but a fresh event survives it
    next_st.irqStatus = (rdIrqStatus ? 6'h00 : st.irqStatus) | setVec;
    if (softReset) begin
      next_st.flag_status_bank      = ASA_FLAG_RST;
      next_st.flag_mask_bank        = ASA_MASK_RST;
      next_st.per_lane_buffer_flags = ASA_LANE_RST;
    end
    // Read data is valid in the cycle after the strobe only
    next_st.rdata  = readStrobe ? readMux : 8'h00;
    next_st.irqOut = |(next_st.irqStatus & next_st.irqMask);
    next_st.pinOut = st.pinSelAlarm ? summary : calStatus;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // Every output straight from a flop
  assign readData              = st.rdata;
  assign irq                   = st.irqOut;
  assign cal_status_output_pin = st.pinOut;
  assign serial_link_enable    = st.linkEnable;
  // Mode flop drives the pin directly; 64b/66b is encoded as 1
  assign linkMode64            = st.mode;

  // Checks on the flag logic
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_clear_div;
    wrStatus && writeData[ASA_B_DIVIDER] && !evt.divMismatch && !softReset;
  endsequence

  sequence s_keep_div;
    wrStatus && !writeData[ASA_B_DIVIDER] && st.flag_status_bank[ASA_B_DIVIDER];
  endsequence

  property p_summary_follows;
    ##1 readData[0] == $past(summary) || !$past(readStrobe) ||
        $past(address) != ASA_OFS_SUMMARY;
  endproperty
  a_summary_follows: assert property (p_summary_follows)
    else $error("summary read does not match unmasked flags");

  property p_mask_hides;
    ((st.flag_status_bank & ~st.flag_mask_bank) == 6'h00) && st.pinSelAlarm
      |=> !cal_status_output_pin;
  endproperty
  a_mask_hides: assert property (p_mask_hides)
    else $error("masked flag reached the alarm pin");

  property p_pin_route;
    st.pinSelAlarm |=> cal_status_output_pin == $past(summary);
  endproperty
  a_pin_route: assert property (p_pin_route)
    else $error("alarm pin does not follow summary");

  property p_lane_flag;
    (|laneHits) |=> st.flag_status_bank[ASA_B_LANE] && (|st.per_lane_buffer_flags);
  endproperty
  a_lane_flag: assert property (p_lane_flag)
    else $error("lane fault did not set lane flag");

  property p_lane_clear_all;
    wrStatus && writeData[ASA_B_LANE] && !softReset && (laneHits == 16'h0000)
      |=> st.per_lane_buffer_flags == 16'h0000;
  endproperty
  a_lane_clear_all: assert property (p_lane_clear_all)
    else $error("lane vector not cleared by lane flag write");

  property p_synth_flag;
    evt.pllUnlock |=> st.flag_status_bank[ASA_B_SYNTH];
  endproperty
  a_synth_flag: assert property (p_synth_flag)
    else $error("unlock did not set synthesizer flag");

  property p_link_8b;
    st.mode == ASA_MODE_8B10B && st.linkEnable && evt.notDataState
      |=> st.flag_status_bank[ASA_B_LINK];
  endproperty
  a_link_8b: assert property (p_link_8b)
    else $error("link flag missed in 8b/10b mode");

  property p_link_start;
    st.mode == ASA_MODE_64B66B && st.linkEnable && !st.prevLinkEnable
      |=> st.flag_status_bank[ASA_B_LINK];
  endproperty
  a_link_start: assert property (p_link_start)
    else $error("link start-up did not set link flag");

  property p_realign_flag;
    evt.sysrefRealign |=> st.flag_status_bank[ASA_B_REALIGN] ##1 1'b1;
  endproperty
  a_realign_flag: assert property (p_realign_flag)
    else $error("realignment did not set flag");

  property p_clear_keep;
    s_keep_div |=> st.flag_status_bank[ASA_B_DIVIDER];
  endproperty
  a_clear_keep: assert property (p_clear_keep)
    else $error("write of 0 cleared a flag");

  property p_clear_one;
    s_clear_div |=> !st.flag_status_bank[ASA_B_DIVIDER];
  endproperty
  a_clear_one: assert property (p_clear_one)
    else $error("write of 1 did not clear flag");

  property p_set_wins;
    wrStatus && writeData[ASA_B_DIVIDER] && evt.divMismatch
      |=> st.flag_status_bank[ASA_B_DIVIDER];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a present set condition");

  property p_soft_reset;
    softReset |=> st.flag_status_bank == ASA_FLAG_RST && st.flag_mask_bank == ASA_MASK_RST;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset did not restore flags and mask");

  property p_unused_quiet;
    wrStatus && writeData[ASA_B_UNUSED] && !softReset
      |=> !st.flag_status_bank[ASA_B_UNUSED] [*2];
  endproperty
  a_unused_quiet: assert property (p_unused_quiet)
    else $error("unused flag set without a source");

endmodule

/* testbench/testbench.sv */
// Self-checking testbench for the alarm status aggregator
`timescale 1ns/1ps
module testbench;
  import asa_pkg::*;

  logic                  core_clk;
  logic                  rst;
  logic [ASA_ADDR_W-1:0] address;
  logic [ASA_DATA_W-1:0] writeData;
  logic                  writeStrobe;
  logic                  readStrobe;
  logic [ASA_DATA_W-1:0] readData;
  logic [ASA_LANES-1:0]  laneFaultRaw;
  logic [ASA_LANES-1:0]  laneActive;
  logic                  pllLockedRaw;
  logic                  notDataStateRaw;
  logic                  linkRealignRaw;
  logic                  sysrefRealignRaw;
  logic                  divMismatchRaw;
  logic                  calStatus;
  logic                  pinOut;
  logic                  linkEnable;
  logic                  linkMode64;
  logic                  irq;
  logic [7:0]            rdVal;
  logic [7:0]            m;
  int                    b;
  int                    errCount;
  int                    samplesChecked;
  int                    srcBits [5] = '{0, 2, 3, 4, 5};

  alarm_status_aggregator dut (
    .core_clk              (core_clk),
    .rst                   (rst),
    .address               (address),
    .writeData             (writeData),
    .writeStrobe           (writeStrobe),
    .readStrobe            (readStrobe),
    .readData              (readData),
    .laneFaultRaw          (laneFaultRaw),
    .laneActive            (laneActive),
    .pllLockedRaw          (pllLockedRaw),
    .notDataStateRaw       (notDataStateRaw),
    .linkRealignRaw        (linkRealignRaw),
    .sysrefRealignRaw      (sysrefRealignRaw),
    .divMismatchRaw        (divMismatchRaw),
    .calStatus             (calStatus),
    .cal_status_output_pin (pinOut),
    .serial_link_enable    (linkEnable),
    .linkMode64            (linkMode64),
    .irq                   (irq)
  );

  // 100 MHz core clock
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // Wait, then step off the edge so registered outputs have landed
  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    writeStrobe <= 1'b1;
    address     <= a;
    writeData   <= d;
    @(posedge core_clk);
    writeStrobe <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a);
    @(posedge core_clk);
    readStrobe <= 1'b1;
    address    <= a;
    @(posedge core_clk);
    readStrobe <= 1'b0;
    #1;
    rdVal = readData;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [7:0] exp, input string what);
    rd(a);
    chk8(rdVal, exp, what);
  endtask

  // Drive one alarm source; sync plus flag update needs three edges
  task automatic setSrc(input int k, input logic v);
    @(posedge core_clk);
    case (k)
      0: divMismatchRaw <= v;
      1: linkRealignRaw <= v;
      2: sysrefRealignRaw <= v;
      3: notDataStateRaw <= v;
      4: pllLockedRaw <= ~v;
      default: laneFaultRaw <= v ? 16'h1028 : 16'h0000;
    endcase
    cycles(4);
  endtask

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    errCount++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    conclude();
  end

  initial begin
    errCount = 0;
    samplesChecked = 0;
    rst = 1'b1;
    address = 12'h000;
    writeData = 8'h00;
    writeStrobe = 1'b0;
    readStrobe = 1'b0;
    laneFaultRaw = 16'h0000;
    laneActive = 16'h1008;
    pllLockedRaw = 1'b1;
    notDataStateRaw = 1'b0;
    linkRealignRaw = 1'b0;
    sysrefRealignRaw = 1'b0;
    divMismatchRaw = 1'b0;
    calStatus = 1'b0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    // Reset values of the register map
    rdChk(ASA_OFS_STATUS, 8'h3F, "status reset");
    rdChk(ASA_OFS_MASK, 8'h3F, "mask reset");
    rdChk(ASA_OFS_SUMMARY, 8'h00, "summary all masked");
    rdChk(ASA_OFS_LANE_LO, 8'hFF, "lane lo reset");
    rdChk(ASA_OFS_LANE_HI, 8'hFF, "lane hi reset");
    rdChk(12'h2C3, 8'h00, "unmapped read");
    // Enable the link, then acknowledge the start-up flags
    wr(ASA_OFS_CTRL, 8'h01);
    chk1(linkEnable, 1'b1, "link enable out");
    wr(ASA_OFS_STATUS, 8'h3F);
    rdChk(ASA_OFS_STATUS, 8'h00, "all acknowledged");
    rdChk(ASA_OFS_LANE_HI, 8'h00, "lane vector cleared");
    wr(ASA_OFS_MASK, 8'hFF);
    rdChk(ASA_OFS_MASK, 8'h3F, "mask reserved bits");
    wr(ASA_OFS_MASK, 8'h00);
    rd(ASA_OFS_IRQ_ST);
    // Interrupt line held low while its mask is clear
    setSrc(2, 1'b1);
    setSrc(2, 1'b0);
    chk1(irq, 1'b0, "irq masked");
    rdChk(ASA_OFS_IRQ_ST, 8'h04, "irq status latched");
    wr(ASA_OFS_STATUS, 8'h04);
    wr(ASA_OFS_IRQ_MASK, 8'h3F);
    rdChk(ASA_OFS_IRQ_MASK, 8'h3F, "irq mask readback");
    // Each source: set, sticky, masking, acknowledge
    foreach (srcBits[i]) begin
      b = srcBits[i];
      m = 8'h01 << b;
      setSrc(b, 1'b1);
      rdChk(ASA_OFS_STATUS, m, "flag set");
      rdChk(ASA_OFS_SUMMARY, 8'h01, "summary unmasked");
      chk1(irq, 1'b1, "irq raised");
      if (b == 5) begin
        rdChk(ASA_OFS_LANE_LO, 8'h08, "active lane only");
        rdChk(ASA_OFS_LANE_HI, 8'h10, "lane 12");
      end
      setSrc(b, 1'b0);
      rdChk(ASA_OFS_IRQ_ST, m, "irq status");
      chk1(irq, 1'b0, "irq cleared by read");
      wr(ASA_OFS_STATUS, 8'h00);
      rdChk(ASA_OFS_STATUS, m, "write 0 keeps flag");
      wr(ASA_OFS_MASK, m);
      rdChk(ASA_OFS_SUMMARY, 8'h00, "masked flag hidden");
      rdChk(ASA_OFS_STATUS, m, "masked flag kept");
      wr(ASA_OFS_MASK, 8'h00);
      if (b == 5) begin
        wr(ASA_OFS_LANE_LO, 8'h08);
        rdChk(ASA_OFS_LANE_LO, 8'h00, "lane bit cleared");
        wr(ASA_OFS_LANE_HI, 8'h00);
        rdChk(ASA_OFS_LANE_HI, 8'h10, "other lane kept");
      end
      wr(ASA_OFS_STATUS, m);
      rdChk(ASA_OFS_STATUS, 8'h00, "flag acknowledged");
      rdChk(ASA_OFS_LANE_HI, 8'h00, "lane vector cleared");
    end
    // A persisting condition beats the clear
    setSrc(0, 1'b1);
    wr(ASA_OFS_STATUS, 8'h01);
    rdChk(ASA_OFS_STATUS, 8'h01, "set wins over clear");
    wr(ASA_OFS_SUMMARY, 8'hFE);
    rdChk(ASA_OFS_SUMMARY, 8'h01, "summary read-only");
    // Pin routing; pin lags summary by one cycle
    wr(ASA_OFS_CTRL, 8'h05);
    cycles(1);
    chk1(pinOut, 1'b1, "pin shows summary");
    wr(ASA_OFS_MASK, 8'h01);
    cycles(1);
    chk1(pinOut, 1'b0, "pin masked summary");
    wr(ASA_OFS_CTRL, 8'h01);
    @(posedge core_clk);
    calStatus <= 1'b1;
    cycles(2);
    chk1(pinOut, 1'b1, "pin shows cal status");
    setSrc(0, 1'b0);
    // 64b/66b: start-up and realignment set the link flag
    wr(ASA_OFS_CTRL, 8'h02);
    chk1(linkMode64, 1'b1, "mode out");
    wr(ASA_OFS_STATUS, 8'h3F);
    wr(ASA_OFS_CTRL, 8'h03);
    cycles(2);
    rdChk(ASA_OFS_STATUS, 8'h08, "64b start-up");
    wr(ASA_OFS_STATUS, 8'h08);
    rdChk(ASA_OFS_STATUS, 8'h00, "64b acknowledged");
    setSrc(1, 1'b1);
    rdChk(ASA_OFS_STATUS, 8'h08, "64b realign");
    setSrc(1, 1'b0);
    // Soft reset restores flags, mask and lane vector
    wr(ASA_OFS_CTRL, 8'h09);
    rdChk(ASA_OFS_STATUS, 8'h3F, "soft reset status");
    rdChk(ASA_OFS_MASK, 8'h3F, "soft reset mask");
    rdChk(ASA_OFS_LANE_LO, 8'hFF, "soft reset lanes");
    rdChk(ASA_OFS_CTRL, 8'h01, "soft reset self clears");
    conclude();
  end
endmodule
